/* core/iom_pkg.sv */
// Package for the I/O channel monitor: register map, fields, timing constants
package iom_pkg;
    localparam int NCH = 8;
    localparam int CLK_HZ = 100_000_000;
    // Time base: 0.1 ms tick
    localparam int TICK_US = 100;
    localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
    // Filter times in ticks (0.1, 1.0, 10, 20 ms)
    localparam logic [11:0] FILT_TICKS [4] = '{12'h001, 12'h00A, 12'h064, 12'h0C8};
    // Extension times in ticks (1.0, 15, 100, 200 ms)
    localparam logic [11:0] EXT_TICKS [4] = '{12'h00A, 12'h096, 12'h3E8, 12'h7D0};
    localparam int INRUSH_MS = 100;
    localparam logic [11:0] INRUSH_TICKS = 12'(INRUSH_MS * 10);
    localparam int SAVE_S = 3600;
    localparam int SAVE_TICKS = SAVE_S * 10_000;
    localparam int LIMIT_SCALE = 1000;
    localparam logic [15:0] LIMIT_MAX = 16'hFDE8;
    localparam logic [15:0] LIMIT_MIN = 16'h0001;
    // Register byte offsets
    localparam logic [11:0] A_CFG = 12'h000;
    localparam logic [11:0] A_IN_MON = 12'h004;
    localparam logic [11:0] A_VLV_MON = 12'h008;
    localparam logic [11:0] A_OPEN_EN = 12'h00C;
    localparam logic [11:0] A_LIMIT = 12'h010;
    localparam logic [11:0] A_CLR = 12'h014;
    localparam logic [11:0] A_STAT = 12'h018;
    localparam logic [11:0] A_MASK = 12'h01C;
    localparam logic [11:0] A_LEVEL = 12'h020;
    localparam logic [11:0] A_CSEL = 12'h024;
    localparam logic [11:0] A_CNT = 12'h028;
    // Config field positions
    localparam int F_FILT = 0;
    localparam int F_EXT = 2;
    localparam int F_SHORT = 4;
    localparam int F_INRUSH = 5;
    localparam logic [5:0] CFG_RST = 6'h15;
    // Status field positions
    localparam int S_IN_CNT = 0;
    localparam int S_VLV_CNT = 8;
    localparam int S_OPEN = 16;
    localparam int S_SHORT = 24;
    localparam int S_OVC = 25;
    typedef struct packed {
        logic [11:0] addr;
        logic write;
        logic [31:0] wdata;
    } iom_req_s;
    typedef struct packed {
        logic [NCH-1:0] in_raw;
        logic [NCH-1:0] vlv;
        logic [NCH-1:0] open;
        logic short_sup;
        logic ovc;
    } iom_field_s;
    function automatic logic [31:0] iom_thresh(input logic [15:0] lim);
        return 32'(lim) * 32'(LIMIT_SCALE);
    endfunction : iom_thresh
endpackage : iom_pkg

/* core/iom_store.sv */
`timescale 1ns/1ps
// Persistent counter store: one word per counter, registered read data
module iom_store
    import iom_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Write port
    input wire logic we,
    input wire logic [3:0] waddr,
    input wire logic [31:0] wdata,
    // Read port
    input wire logic [3:0] raddr,
    output logic [31:0] rdata
);
    // No reset: contents must survive power cycles
    logic [31:0] mem [2*NCH];
    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : iom_store

/* core/iom_top.sv */
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
// I/O channel monitor: input filter/extension, on/off counters, fault flags
//
// Contract
// R1 - Input level changes shorter than the selected filter time 0.1/1/10/20 ms (default 1 ms) are ignored.
// R2 - Each detected input stays asserted for at least the extension time 1/15/100/200 ms (default 15 ms).
// R3 - With monitoring on, valve switch operations are counted and an error raised above the limit 1..65000.
// R4 - With monitoring on (off by default), input on/off transitions are counted and flagged above the limit.
// R5 - The count is compared against the limit times 1000.
// R6 - Counts are saved hourly to persistent store and reloaded after power-up.
// R7 - A clear request sets that channel's count to zero.
// R8 - A sensor supply short raises an error only when its detection is enabled (default on).
// R9 - An open sensor raises an error when per-channel open detection is enabled (default off).
// R10 - Inrush masking, when on (default off), suppresses overcurrent detection 100 ms after power-up.
// R11 - Filter and extension times count ticks of a fixed time base; the filter restarts on each raw change, the extension restarts on the filtered rise.
// R12 - Raised errors are sticky status flags, kept while the condition lasts; a flag stays set until cleared with the condition gone.
module iom_top
    import iom_pkg::*;
#(
    parameter int SAVE_PERIOD = SAVE_TICKS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Field side
    input wire iom_field_s field,
    output logic [NCH-1:0] in_out,
    output logic irq
);
    iom_req_s req;
    assign req = '{addr: paddr, write: pwrite, wdata: pwdata};

    typedef enum logic [1:0] {ST_LOAD, ST_WAIT, ST_RUN} iom_state_e;

    // Registers
    logic [5:0] cfg_ff, nxt_cfg;
    logic [NCH-1:0] in_mon_ff, nxt_in_mon, vlv_mon_ff, nxt_vlv_mon, open_en_ff, nxt_open_en;
    logic [15:0] limit_ff, nxt_limit;
    logic [31:0] stat_ff, nxt_stat, mask_ff, nxt_mask, rd_ff, nxt_rd;
    logic [3:0] csel_ff, nxt_csel;
    logic rdy_ff, nxt_rdy, err_ff, nxt_err, irq_ff, nxt_irq;
    // Time base and filters
    logic [13:0] div_ff, nxt_div;
    logic tick;
    logic [NCH-1:0] raw_ff, nxt_raw, filt_ff, nxt_filt, out_ff, nxt_out, vprev_ff, nxt_vprev;
    logic [11:0] fcnt_ff [NCH], nxt_fcnt [NCH];
    logic [11:0] ecnt_ff [NCH], nxt_ecnt [NCH];
    logic [11:0] inrush_ff, nxt_inrush;
    // Counters and store
    logic [31:0] cnt_ff [2*NCH], nxt_cnt [2*NCH];
    iom_state_e st_ff, nxt_st;
    logic [4:0] idx_ff, nxt_idx;
    logic [31:0] save_ff, nxt_save;
    logic we;
    logic [3:0] waddr, raddr;
    logic [31:0] wdata, sdata;

    iom_store u_store (
        .sys_clk(sys_clk),
        .we(we),
        .waddr(waddr),
        .wdata(wdata),
        .raddr(raddr),
        .rdata(sdata)
    );

    logic acc, wr;
    logic [2*NCH-1:0] clr_req, ev;
    logic [1:0] fsel, esel;
    assign acc = psel && penable && rdy_ff;
    assign wr = acc && req.write;
    assign fsel = cfg_ff[F_FILT +: 2];
    assign esel = cfg_ff[F_EXT +: 2];
    assign tick = (div_ff == 14'(TICK_CYC - 1));

    // Register file
    always_comb begin
        nxt_cfg = cfg_ff;
        nxt_in_mon = in_mon_ff;
        nxt_vlv_mon = vlv_mon_ff;
        nxt_open_en = open_en_ff;
        nxt_limit = limit_ff;
        nxt_mask = mask_ff;
        nxt_csel = csel_ff;
        nxt_rd = rd_ff;
        // Decoded in setup so the error stands beside pready
        nxt_err = psel && !penable && !(req.addr inside {A_CFG, A_IN_MON, A_VLV_MON,
            A_OPEN_EN, A_LIMIT, A_CLR, A_STAT, A_MASK, A_LEVEL, A_CSEL, A_CNT});
        clr_req = '0;
        // Ready in the first access cycle: no wait state
        nxt_rdy = psel && !rdy_ff && !(penable && rdy_ff);
        if (acc) begin
            nxt_rdy = 1'b0;
        end
        if (wr) begin
            unique case (req.addr)
                A_CFG: nxt_cfg = req.wdata[5:0];
                A_IN_MON: nxt_in_mon = req.wdata[NCH-1:0];
                A_VLV_MON: nxt_vlv_mon = req.wdata[NCH-1:0];
                A_OPEN_EN: nxt_open_en = req.wdata[NCH-1:0];
                A_LIMIT: begin
                    // Out-of-range limits are dropped silently
                    if (req.wdata[15:0] >= LIMIT_MIN && req.wdata[15:0] <= LIMIT_MAX) begin
                        nxt_limit = req.wdata[15:0];
                    end
                end
                A_CLR: clr_req = req.wdata[2*NCH-1:0]; // R7
                A_STAT: ;
                A_MASK: nxt_mask = req.wdata;
                A_CSEL: nxt_csel = req.wdata[3:0];
                default: ;
            endcase
        end else if (psel && !penable) begin
            unique case (req.addr)
                A_CFG: nxt_rd = 32'(cfg_ff);
                A_IN_MON: nxt_rd = 32'(in_mon_ff);
                A_VLV_MON: nxt_rd = 32'(vlv_mon_ff);
                A_OPEN_EN: nxt_rd = 32'(open_en_ff);
                A_LIMIT: nxt_rd = 32'(limit_ff);
                A_CLR: nxt_rd = '0;
                A_STAT: nxt_rd = stat_ff; // R12
                A_MASK: nxt_rd = mask_ff;
                A_LEVEL: nxt_rd = 32'(out_ff);
                A_CSEL: nxt_rd = 32'(csel_ff);
                A_CNT: nxt_rd = cnt_ff[csel_ff];
                default: nxt_rd = '0;
            endcase
        end
        nxt_irq = |(stat_ff & mask_ff);
    end

    // Time base, filters, extension, inrush window
    always_comb begin
        nxt_div = tick ? '0 : div_ff + 14'h0001;
        nxt_raw = field.in_raw;
        nxt_filt = filt_ff;
        nxt_out = out_ff;
        nxt_inrush = inrush_ff;
        if (tick && inrush_ff != INRUSH_TICKS) begin
            nxt_inrush = inrush_ff + 12'h001;
        end
        for (int i = 0; i < NCH; i++) begin
            nxt_fcnt[i] = fcnt_ff[i];
            nxt_ecnt[i] = ecnt_ff[i];
            if (field.in_raw[i] != raw_ff[i]) begin
                nxt_fcnt[i] = '0; // R11
            end else if (field.in_raw[i] != filt_ff[i]) begin
                if (tick) begin
                    nxt_fcnt[i] = fcnt_ff[i] + 12'h001;
                end
                // One tick more: the first tick may follow the change at once
                if (fcnt_ff[i] > FILT_TICKS[fsel]) begin
                    nxt_filt[i] = field.in_raw[i]; // R1
                    nxt_fcnt[i] = '0;
                end
            end else begin
                nxt_fcnt[i] = '0;
            end
            if (nxt_filt[i] && !filt_ff[i]) begin
                nxt_out[i] = 1'b1;
                nxt_ecnt[i] = '0; // R11
            end else if (out_ff[i] && !filt_ff[i]) begin
                if (ecnt_ff[i] > EXT_TICKS[esel]) begin
                    nxt_out[i] = 1'b0; // R2
                end else if (tick) begin
                    nxt_ecnt[i] = ecnt_ff[i] + 12'h001;
                end
            end else if (filt_ff[i]) begin
                if (tick && ecnt_ff[i] <= EXT_TICKS[esel]) begin
                    nxt_ecnt[i] = ecnt_ff[i] + 12'h001;
                end
            end
        end
        nxt_vprev = field.vlv;
    end

    // Counters, restore and hourly save
    always_comb begin
        ev = {field.vlv & ~vprev_ff & vlv_mon_ff, out_ff & ~nxt_out & in_mon_ff}; // R3 R4
        nxt_st = st_ff;
        nxt_idx = idx_ff;
        nxt_save = save_ff;
        we = 1'b0;
        waddr = idx_ff[3:0];
        wdata = '0;
        raddr = idx_ff[3:0];
        for (int c = 0; c < 2 * NCH; c++) begin
            nxt_cnt[c] = cnt_ff[c];
            if (st_ff == ST_RUN && ev[c] && cnt_ff[c] != 32'hFFFFFFFF) begin
                nxt_cnt[c] = cnt_ff[c] + 32'h1;
            end
            if (clr_req[c]) begin
                nxt_cnt[c] = '0; // R7
            end
        end
        unique case (st_ff)
            ST_LOAD: nxt_st = ST_WAIT;
            ST_WAIT: begin
                nxt_cnt[idx_ff[3:0]] = sdata; // R6
                nxt_idx = idx_ff + 5'h01;
                nxt_st = (idx_ff == 5'(2 * NCH - 1)) ? ST_RUN : ST_LOAD;
                if (idx_ff == 5'(2 * NCH - 1)) begin
                    nxt_idx = '0;
                end
            end
            ST_RUN: begin
                if (tick) begin
                    nxt_save = (save_ff == 32'(SAVE_PERIOD - 1)) ? '0 : save_ff + 32'h1;
                end
                if (tick && save_ff == 32'(SAVE_PERIOD - 1)) begin
                    nxt_idx = 5'h10;
                end
                if (idx_ff[4]) begin
                    we = 1'b1; // R6
                    wdata = cnt_ff[idx_ff[3:0]];
                    nxt_idx = (idx_ff == 5'h1F) ? '0 : idx_ff + 5'h01;
                end
            end
        endcase
    end

    // Sticky status: set wins over write-one clear
    always_comb begin
        logic [31:0] set;
        set = '0;
        for (int c = 0; c < NCH; c++) begin
            set[S_IN_CNT + c] = in_mon_ff[c] && cnt_ff[c] > iom_thresh(limit_ff); // R4 R5
            set[S_VLV_CNT + c] = vlv_mon_ff[c] && cnt_ff[NCH + c] > iom_thresh(limit_ff); // R3 R5
        end
        set[S_OPEN +: NCH] = field.open & open_en_ff; // R9
        set[S_SHORT] = field.short_sup && cfg_ff[F_SHORT]; // R8
        set[S_OVC] = field.ovc && !(cfg_ff[F_INRUSH] && inrush_ff != INRUSH_TICKS); // R10
        nxt_stat = stat_ff;
        if (wr && req.addr == A_STAT) begin
            nxt_stat = stat_ff & ~req.wdata;
        end
        nxt_stat = nxt_stat | set; // R12
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cfg_ff <= CFG_RST;
            in_mon_ff <= '0;
            vlv_mon_ff <= '0;
            open_en_ff <= '0;
            limit_ff <= LIMIT_MIN;
            stat_ff <= '0;
            mask_ff <= '0;
            rd_ff <= '0;
            csel_ff <= '0;
            rdy_ff <= 1'b0;
            err_ff <= 1'b0;
            irq_ff <= 1'b0;
            div_ff <= '0;
            raw_ff <= '0;
            filt_ff <= '0;
            out_ff <= '0;
            vprev_ff <= '0;
            inrush_ff <= '0;
            st_ff <= ST_LOAD;
            idx_ff <= '0;
            save_ff <= '0;
            for (int i = 0; i < NCH; i++) begin
                fcnt_ff[i] <= '0;
                ecnt_ff[i] <= '0;
            end
            for (int c = 0; c < 2 * NCH; c++) begin
                cnt_ff[c] <= '0;
            end
        end else begin
            cfg_ff <= nxt_cfg;
            in_mon_ff <= nxt_in_mon;
            vlv_mon_ff <= nxt_vlv_mon;
            open_en_ff <= nxt_open_en;
            limit_ff <= nxt_limit;
            stat_ff <= nxt_stat;
            mask_ff <= nxt_mask;
            rd_ff <= nxt_rd;
            csel_ff <= nxt_csel;
            rdy_ff <= nxt_rdy;
            err_ff <= nxt_err;
            irq_ff <= nxt_irq;
            div_ff <= nxt_div;
            raw_ff <= nxt_raw;
            filt_ff <= nxt_filt;
            out_ff <= nxt_out;
            vprev_ff <= nxt_vprev;
            inrush_ff <= nxt_inrush;
            st_ff <= nxt_st;
            idx_ff <= nxt_idx;
            save_ff <= nxt_save;
            fcnt_ff <= nxt_fcnt;
            ecnt_ff <= nxt_ecnt;
            cnt_ff <= nxt_cnt;
        end
    end

    assign prdata = rd_ff;
    assign pready = rdy_ff;
    assign pslverr = err_ff;
    assign in_out = out_ff;
    assign irq = irq_ff;
endmodule : iom_top

/* tb/iom_checker.sv */
`timescale 1ns/1ps
// Port-level assertions for the I/O channel monitor
module iom_checker
    import iom_pkg::*;
#(
    parameter int SAVE_PERIOD = SAVE_TICKS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Field side
    input wire iom_field_s field,
    input wire logic [NCH-1:0] in_out,
    input wire logic irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    wait_state_a: assert property (psel && !penable |=> pready)
        else $error("pready not in first access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_scope_a: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    reset_idle_a: assert property ($rose(nrst) |-> !pready && !irq && in_out == '0)
        else $error("outputs not idle after reset");
    slverr_ok_a: assert property (pready && paddr <= A_CNT && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("error response on a mapped address");
    slverr_bad_a: assert property (pready && paddr > A_CNT |-> pslverr)
        else $error("no error response on an unmapped address");
    unmapped_zero_a: assert property (pready && !pwrite && paddr > A_CNT |-> prdata == '0)
        else $error("unmapped read not zero");
    level_read_a: assert property (
        pready && !pwrite && paddr == A_LEVEL |-> prdata == 32'($past(in_out)))
        else $error("level read differs from input outputs");
    // Interrupt must settle once every source is masked
    mask_quiet_a: assert property (
        pready && pwrite && paddr == A_MASK && pwdata == '0 |-> ##3 !irq)
        else $error("irq high with all sources masked");
    rdata_hold_a: assert property (pready && !pwrite |=> $stable(prdata))
        else $error("read data moved after access");
    cover property (pready && pwrite && paddr == A_CLR);
    cover property ($rose(irq));
    cover property ($rose(in_out[0]));
endmodule : iom_checker
bind iom_top iom_checker #(.SAVE_PERIOD(SAVE_PERIOD)) i_iom_checker (.sys_clk(sys_clk),
    .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .field(field),
    .in_out(in_out), .irq(irq));

/* tb/iom_field_model.sv */
`timescale 1ns/1ps
// Field-side model: valve drives, sensor levels and fault lines
module iom_field_model
    import iom_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Field lines toward the monitor
    output iom_field_s field
);
    initial field = '0;
    task automatic vlv_pulses(input int ch, input int n);
        repeat (n) begin
            field.vlv[ch] <= 1'b1;
            @(posedge sys_clk);
            field.vlv[ch] <= 1'b0;
            @(posedge sys_clk);
        end
    endtask : vlv_pulses
    task automatic in_drive(input logic [NCH-1:0] v, input int n);
        field.in_raw <= v;
        repeat (n) @(posedge sys_clk);
    endtask : in_drive
    task automatic faults(input logic s, input logic o, input logic [NCH-1:0] op);
        field.short_sup <= s;
        field.ovc <= o;
        field.open <= op;
        @(posedge sys_clk);
    endtask : faults
endmodule : iom_field_model

/* tb/iom_top_tb.sv */
`timescale 1ns/1ps
// Self-checking bench for the I/O channel monitor
module iom_top_tb;
    import iom_pkg::*;
    localparam int SAVE_P = 2;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NCH-1:0] in_out;
    logic irq;
    iom_field_s field;
    logic [63:0] exp_q[$];
    logic [63:0] note;
    logic [31:0] vbit;
    logic [31:0] rnd;
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;
    int ch;
    iom_top #(.SAVE_PERIOD(SAVE_P)) i_iom_top (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .field(field),
        .in_out(in_out), .irq(irq));
    iom_field_model i_iom_field_model (.sys_clk(sys_clk), .field(field));
    always #5 sys_clk = ~sys_clk;
    task automatic final_report();
        $display("Counts: %0d checks, %0d mismatches", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Read results are judged here, in issue order
    always @(posedge sys_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            chk(prdata & note[63:32], note[31:0]);
        end
        cycles++;
        if (cycles > 90000) begin
            fail_count++;
            final_report();
        end
    end
    // Request held until pready; the trailing idle edge avoids double drives
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back({m, e & m});
        apb(1'b0, a, 32'h00000000);
    endtask : rd
    task automatic do_reset();
        nrst <= 1'b0;
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        // Counter restore from the store runs 32 cycles
        repeat (40) @(posedge sys_clk);
    endtask : do_reset
    initial begin
        rnd = $urandom(48594);
        do_reset();
        // Store is undefined until first save, so start from cleared counters
        wr(A_CLR, 32'h0000FFFF);
        wr(A_STAT, 32'h03FFFFFF);
        rd(A_CFG, 32'h00000015, 32'h0000003F);
        rd(A_IN_MON, 32'h0, 32'h000000FF);
        rd(A_OPEN_EN, 32'h0, 32'h000000FF);
        rd(A_LIMIT, 32'h00000001, 32'h0000FFFF);
        wr(A_LIMIT, 32'h00000000);
        rd(A_LIMIT, 32'h00000001, 32'h0000FFFF);
        wr(A_LIMIT, 32'h0000FDE9);
        rd(A_LIMIT, 32'h00000001, 32'h0000FFFF);
        wr(A_LIMIT, 32'h0000FDE8);
        rd(A_LIMIT, 32'h0000FDE8, 32'h0000FFFF);
        wr(A_LIMIT, 32'h00000001);
        rnd = $urandom() & 32'h03FFFFFF;
        wr(A_MASK, rnd);
        rd(A_MASK, rnd, 32'h03FFFFFF);
        wr(A_MASK, 32'h00000000);
        rd(12'h0FC, 32'h0, ALL);
        $display("Test registers done");
        ch = $urandom_range(7);
        vbit = 32'h00000100 << ch;
        wr(A_VLV_MON, 32'h00000001 << ch);
        wr(A_MASK, vbit);
        wr(A_CSEL, 32'(8 + ch));
        i_iom_field_model.vlv_pulses(ch, LIMIT_SCALE);
        rd(A_CNT, 32'(LIMIT_SCALE), ALL);
        rd(A_STAT, 32'h0, vbit);
        i_iom_field_model.vlv_pulses(ch, 1);
        rd(A_STAT, vbit, vbit);
        chk({31'h0, irq}, 32'h1);
        wr(A_STAT, vbit);
        rd(A_STAT, vbit, vbit);
        wr(A_CLR, vbit);
        rd(A_CNT, 32'h0, ALL);
        wr(A_STAT, vbit);
        rd(A_STAT, 32'h0, vbit);
        chk({31'h0, irq}, 32'h0);
        i_iom_field_model.vlv_pulses(ch, 5);
        $display("Test valve counter done");
        i_iom_field_model.faults(1'b1, 1'b1, 8'h0C);
        wr(A_OPEN_EN, 32'h00000004);
        repeat (4) @(posedge sys_clk);
        rd(A_STAT, 32'h03040000, 32'h030C0000);
        wr(A_CFG, 32'h00000000);
        wr(A_STAT, 32'h01000000);
        rd(A_STAT, 32'h0, 32'h01000000);
        i_iom_field_model.faults(1'b0, 1'b0, 8'h00);
        wr(A_STAT, 32'h03FF0000);
        $display("Test faults done");
        wr(A_IN_MON, 32'h00000001);
        // A glitch far below one tick must not pass the filter
        i_iom_field_model.in_drive(8'h01, 20);
        i_iom_field_model.in_drive(8'h00, TICK_CYC);
        rd(A_LEVEL, 32'h0, 32'h000000FF);
        i_iom_field_model.in_drive(8'h01, TICK_CYC * 5 / 2);
        rd(A_LEVEL, 32'h1, 32'h000000FF);
        i_iom_field_model.in_drive(8'h00, TICK_CYC * 3);
        rd(A_LEVEL, 32'h1, 32'h000000FF);
        $display("Test input filter done");
        do_reset();
        wr(A_CFG, 32'h00000031);
        i_iom_field_model.faults(1'b0, 1'b1, 8'h00);
        repeat (8) @(posedge sys_clk);
        rd(A_STAT, 32'h0, 32'h02000000);
        wr(A_CSEL, 32'(8 + ch));
        rd(A_CNT, 32'h5, ALL);
        i_iom_field_model.faults(1'b0, 1'b0, 8'h00);
        $display("Test restore and inrush done");
        final_report();
    end
endmodule : iom_top_tb
